// [hdl/ufb_pkg.sv]
package ufb_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_FMT  = 3'h2;
  localparam logic [2:0] ADDR_BCON = 3'h3;
  localparam logic [2:0] ADDR_RLL  = 3'h4;
  localparam logic [2:0] ADDR_RLH  = 3'h5;
  localparam logic [2:0] ADDR_MASK = 3'h6;

  // serial_control_reg bits; the mask register shares this layout
  localparam int CB_OVR  = 7;
  localparam int CB_PERR = 6;
  localparam int CB_THRE = 5;
  localparam int CB_REN  = 4;
  localparam int CB_TBX  = 3;
  localparam int CB_RBX  = 2;
  localparam int CB_TI   = 1;
  localparam int CB_RI   = 0;

  // serial_format_reg bits
  localparam int FB_MCE   = 7;
  localparam int FB_PT_HI = 6;
  localparam int FB_PT_LO = 5;
  localparam int FB_PE    = 4;
  localparam int FB_STOP2 = 3;
  localparam int FB_XBE   = 2;
  localparam int FB_LEN_HI = 1;
  localparam int FB_LEN_LO = 0;

  // baud_gen_control bits
  localparam int BB_EN    = 6;
  localparam int BB_PS_HI = 1;
  localparam int BB_PS_LO = 0;

  // prescale_select codes and terminal counts (divide minus one)
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4  = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_DIV1  = 2'h3;
  localparam logic [5:0] PRE_LIM1  = 6'h00;
  localparam logic [5:0] PRE_LIM4  = 6'h03;
  localparam logic [5:0] PRE_LIM12 = 6'h0B;
  localparam logic [5:0] PRE_LIM48 = 6'h2F;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;

  // Parity types
  localparam logic [1:0] PT_ODD   = 2'h0;
  localparam logic [1:0] PT_EVEN  = 2'h1;
  localparam logic [1:0] PT_MARK  = 2'h2;
  localparam logic [1:0] PT_SPACE = 2'h3;

  localparam logic [2:0] DATA_LAST_BASE = 3'h4;
  localparam logic [2:0] LEN_MAX_CODE   = 3'h3;
  localparam int         FIFO_DEPTH     = 3;
  localparam logic [1:0] FIFO_EMPTY     = 2'h0;
  localparam logic [1:0] FIFO_FULL      = 2'h3;
  localparam logic [1:0] FIFO_LAST_IDX  = 2'h2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FMT_RESET  = 8'h03;
  localparam logic [7:0] BCON_RESET = 8'h00;
  localparam logic [7:0] RL_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_EXTRA = 5'h08, TX_STOP = 5'h10
  } ufb_tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_EXTRA = 5'h08, RX_STOP = 5'h10
  } ufb_rx_state_t;
endpackage

// [hdl/ufb_baud_gen.sv]
`timescale 1ns/10ps
module ufb_baud_gen (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic        gen_en,
  input  wire logic [1:0]  prescale_select,
  input  wire logic [15:0] reload,
  input  wire logic        restart,
  // Overflow tick, one per half bit
  output logic             tick_r
);
  import ufb_pkg::*;

  logic [5:0]  pre_r, pre_nxt, pre_lim;
  logic [15:0] tmr_r, tmr_nxt;
  logic        tick_nxt;

  always_comb begin
    case (prescale_select)
      PS_DIV1:  pre_lim = PRE_LIM1;
      PS_DIV4:  pre_lim = PRE_LIM4;
      PS_DIV48: pre_lim = PRE_LIM48;
      default:  pre_lim = PRE_LIM12;
    endcase
    pre_nxt  = pre_r;
    tmr_nxt  = tmr_r;
    tick_nxt = 1'b0;
    if (!gen_en || restart) begin
      // Restart aligns the bit grid to a start edge
      pre_nxt = '0;
      tmr_nxt = reload;
    end else if (pre_r == pre_lim) begin
      pre_nxt = '0;
      if (tmr_r == TIMER_MAX) begin
        tmr_nxt  = reload;
        tick_nxt = 1'b1;
      end else begin
        tmr_nxt = tmr_r + 16'h0001;
      end
    end else begin
      pre_nxt = pre_r + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r  <= '0;
      tmr_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      tmr_r  <= tmr_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// [hdl/ufb_uart.sv]
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module ufb_uart (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial lines
  input  wire logic       rx_pin,
  output logic            tx_pin,
  // Interrupt
  output logic            irq
);
  import ufb_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] fmt_r, fmt_nxt, bcon_r, bcon_nxt, rll_r, rll_nxt, rlh_r, rlh_nxt;
  logic [7:0] mask_r, mask_nxt, rdata_r, rdata_nxt;
  logic       ren_r, ren_nxt, tbx_r, tbx_nxt, irq_r, irq_nxt;
  logic       ti_r, ti_nxt, ri_r, ri_nxt, ovr_r, ovr_nxt, perr_r, perr_nxt;
  logic       data_wr, ctrl_wr, gen_en, pe, xbe, stop2;
  logic [1:0] ptype;
  logic [2:0] len3, last_idx;
  logic       tx_tick, rx_tick, tx_restart, rx_restart;

  assign data_wr  = reg_wr && (reg_addr == ADDR_DATA);
  assign ctrl_wr  = reg_wr && (reg_addr == ADDR_CTRL);
  assign gen_en   = bcon_r[BB_EN];
  assign pe       = fmt_r[FB_PE];
  assign xbe      = fmt_r[FB_XBE];
  assign stop2    = fmt_r[FB_STOP2];
  assign ptype    = fmt_r[FB_PT_HI:FB_PT_LO];
  assign len3     = {1'b0, fmt_r[FB_LEN_HI:FB_LEN_LO]};
  assign last_idx = len3 + DATA_LAST_BASE;

  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] ln,
                                   input logic [1:0] pt);
    logic x;
    x = ^(d & (8'hFF >> (LEN_MAX_CODE - ln)));
    case (pt)
      PT_EVEN: par_bit = x;
      PT_ODD:  par_bit = ~x;
      PT_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // Separate timers so the receiver can realign to each start edge
  ufb_baud_gen u_tx_baud (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .gen_en          (gen_en),
    .prescale_select (bcon_r[BB_PS_HI:BB_PS_LO]),
    .reload          ({rlh_r, rll_r}),
    .restart         (tx_restart),
    .tick_r          (tx_tick)
  );

  ufb_baud_gen u_rx_baud (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .gen_en          (gen_en),
    .prescale_select (bcon_r[BB_PS_HI:BB_PS_LO]),
    .reload          ({rlh_r, rll_r}),
    .restart         (rx_restart),
    .tick_r          (rx_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter
  ufb_tx_state_t tx_st_r, tx_st_nxt;
  logic [7:0] thr_r, thr_nxt, tx_sh_r, tx_sh_nxt;
  logic [2:0] tx_cnt_r, tx_cnt_nxt;
  logic       thre_r, thre_nxt, tx_half_r, tx_half_nxt, tx_ext_r, tx_ext_nxt;
  logic       txd_r, txd_nxt, tx_end, ti_set;

  always_comb begin
    tx_st_nxt   = tx_st_r;
    thr_nxt     = thr_r;
    thre_nxt    = thre_r;
    tx_sh_nxt   = tx_sh_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_ext_nxt  = tx_ext_r;
    txd_nxt     = txd_r;
    tx_restart  = 1'b0;
    ti_set      = 1'b0;
    tx_half_nxt = tx_tick ? ~tx_half_r : tx_half_r;
    tx_end      = tx_tick && tx_half_r;
    case (tx_st_r)
      TX_IDLE: begin
        txd_nxt = 1'b1;
        if (gen_en && !thre_r) begin
          tx_sh_nxt   = thr_r;
          thre_nxt    = 1'b1;
          tx_ext_nxt  = pe ? par_bit(thr_r, len3, ptype) : tbx_r;
          tx_st_nxt   = TX_START;
          txd_nxt     = 1'b0;
          tx_restart  = 1'b1;
          tx_half_nxt = 1'b0;
        end
      end
      TX_START: if (tx_end) begin
        tx_st_nxt  = TX_DATA;
        txd_nxt    = tx_sh_r[0];
        tx_cnt_nxt = '0;
      end
      TX_DATA: if (tx_end) begin
        if (tx_cnt_r == last_idx) begin
          tx_cnt_nxt = '0;
          if (pe || xbe) begin
            tx_st_nxt = TX_EXTRA;
            txd_nxt   = tx_ext_r;
          end else begin
            tx_st_nxt = TX_STOP;
            txd_nxt   = 1'b1;
            ti_set    = 1'b1;
          end
        end else begin
          tx_sh_nxt  = tx_sh_r >> 1;
          txd_nxt    = tx_sh_r[1];
          tx_cnt_nxt = tx_cnt_r + 3'h1;
        end
      end
      TX_EXTRA: if (tx_end) begin
        tx_st_nxt = TX_STOP;
        txd_nxt   = 1'b1;
        ti_set    = 1'b1;
      end
      TX_STOP: if (tx_end) begin
        if (stop2 && (tx_cnt_r == '0)) tx_cnt_nxt = 3'h1;
        else tx_st_nxt = TX_IDLE;
      end
      default: begin
        tx_st_nxt = TX_IDLE;
        txd_nxt   = 1'b1;
      end
    endcase
    if (!gen_en) begin
      tx_st_nxt = TX_IDLE;
      txd_nxt   = 1'b1;
    end
    // A write in the transfer cycle still lands and keeps the holder full
    if (data_wr) begin
      thr_nxt  = reg_wdata;
      thre_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r   <= TX_IDLE;
      thr_r     <= '0;
      thre_r    <= 1'b1;
      tx_sh_r   <= '0;
      tx_cnt_r  <= '0;
      tx_ext_r  <= 1'b0;
      tx_half_r <= 1'b0;
      txd_r     <= 1'b1;
    end else begin
      tx_st_r   <= tx_st_nxt;
      thr_r     <= thr_nxt;
      thre_r    <= thre_nxt;
      tx_sh_r   <= tx_sh_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_ext_r  <= tx_ext_nxt;
      tx_half_r <= tx_half_nxt;
      txd_r     <= txd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver; a pin level counts once the second and third stages agree
  ufb_rx_state_t rx_st_r, rx_st_nxt;
  logic       rx_s1_r, rx_s2_r, rx_s3_r, rx_line_r, rx_line_nxt, rx_prev_r;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_data;
  logic [2:0] rx_cnt_r, rx_cnt_nxt;
  logic       rx_half_r, rx_half_nxt, rx_ext_r, rx_ext_nxt, rx_ok_r, rx_ok_nxt;
  logic       rx_end, rx_good, rx_push, ri_set, ovr_set, perr_set, rx_xbit;
  logic [8:0] rx_word;
  logic [1:0] cnt_r;

  always_comb begin
    rx_line_nxt = (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_line_r;
    rx_st_nxt   = rx_st_r;
    rx_sh_nxt   = rx_sh_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_ext_nxt  = rx_ext_r;
    rx_ok_nxt   = rx_ok_r;
    rx_restart  = 1'b0;
    rx_good     = 1'b0;
    rx_half_nxt = rx_tick ? ~rx_half_r : rx_half_r;
    rx_end      = rx_tick && rx_half_r;
    rx_data     = rx_sh_r >> (LEN_MAX_CODE - len3);
    rx_xbit     = (xbe && !pe) ? rx_ext_r : rx_line_r;
    case (rx_st_r)
      RX_IDLE: if (ren_r && rx_prev_r && !rx_line_r) begin
        rx_st_nxt   = RX_START;
        rx_restart  = 1'b1;
        rx_half_nxt = 1'b0;
      end
      // First tick is mid start bit; false starts are dropped
      RX_START: if (rx_tick) begin
        rx_st_nxt   = rx_line_r ? RX_IDLE : RX_DATA;
        rx_half_nxt = 1'b0;
        rx_cnt_nxt  = '0;
        rx_ok_nxt   = 1'b1;
      end
      RX_DATA: if (rx_end) begin
        rx_sh_nxt = {rx_line_r, rx_sh_r[7:1]};
        if (rx_cnt_r == last_idx) begin
          rx_cnt_nxt = '0;
          rx_st_nxt  = (pe || xbe) ? RX_EXTRA : RX_STOP;
        end else begin
          rx_cnt_nxt = rx_cnt_r + 3'h1;
        end
      end
      RX_EXTRA: if (rx_end) begin
        rx_ext_nxt = rx_line_r;
        rx_st_nxt  = RX_STOP;
      end
      RX_STOP: if (rx_end) begin
        rx_ok_nxt = rx_ok_r && rx_line_r;
        if (stop2 && (rx_cnt_r == '0)) begin
          rx_cnt_nxt = 3'h1;
        end else begin
          rx_st_nxt = RX_IDLE;
          rx_good   = rx_ok_r && rx_line_r;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (!gen_en) rx_st_nxt = RX_IDLE;
    rx_word  = {rx_xbit, rx_data};
    rx_push  = rx_good && (cnt_r != FIFO_FULL);
    ovr_set  = rx_good && (cnt_r == FIFO_FULL);
    perr_set = rx_good && pe && (rx_ext_r != par_bit(rx_data, len3, ptype));
    ri_set   = rx_push && (!fmt_r[FB_MCE] || rx_xbit);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_s3_r   <= 1'b1;
      rx_line_r <= 1'b1;
      rx_prev_r <= 1'b1;
      rx_st_r   <= RX_IDLE;
      rx_sh_r   <= '0;
      rx_cnt_r  <= '0;
      rx_ext_r  <= 1'b0;
      rx_ok_r   <= 1'b0;
      rx_half_r <= 1'b0;
    end else begin
      rx_s1_r   <= rx_pin;
      rx_s2_r   <= rx_s1_r;
      rx_s3_r   <= rx_s2_r;
      rx_line_r <= rx_line_nxt;
      rx_prev_r <= rx_line_r;
      rx_st_r   <= rx_st_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_ext_r  <= rx_ext_nxt;
      rx_ok_r   <= rx_ok_nxt;
      rx_half_r <= rx_half_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive FIFO, three entries
  logic [8:0] mem_r [FIFO_DEPTH];
  logic [8:0] mem_nxt [FIFO_DEPTH];
  logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt, cnt_nxt;
  logic       pop;

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == FIFO_LAST_IDX) ? FIFO_EMPTY : p + 2'h1;
  endfunction

  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_ent
    always_comb begin
      mem_nxt[i] = (rx_push && (wp_r == 2'(i))) ? rx_word : mem_r[i];
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) mem_r[i] <= '0;
      else mem_r[i] <= mem_nxt[i];
    end
  end

  always_comb begin
    pop     = reg_rd && (reg_addr == ADDR_DATA) && (cnt_r != FIFO_EMPTY);
    wp_nxt  = rx_push ? ptr_inc(wp_r) : wp_r;
    rp_nxt  = pop ? ptr_inc(rp_r) : rp_r;
    cnt_nxt = cnt_r + {1'b0, rx_push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= FIFO_EMPTY;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers, flags and interrupt; a hardware set beats a same-cycle clear
  logic [7:0] ctrl_view, flag_nxt;

  always_comb begin
    fmt_nxt  = (reg_wr && reg_addr == ADDR_FMT)  ? reg_wdata : fmt_r;
    bcon_nxt = (reg_wr && reg_addr == ADDR_BCON) ? reg_wdata : bcon_r;
    rll_nxt  = (reg_wr && reg_addr == ADDR_RLL)  ? reg_wdata : rll_r;
    rlh_nxt  = (reg_wr && reg_addr == ADDR_RLH)  ? reg_wdata : rlh_r;
    mask_nxt = (reg_wr && reg_addr == ADDR_MASK) ? reg_wdata : mask_r;
    ren_nxt  = ctrl_wr ? reg_wdata[CB_REN] : ren_r;
    tbx_nxt  = ctrl_wr ? reg_wdata[CB_TBX] : tbx_r;
    // Only software writes of one clear the flags; RI clears only while the FIFO is empty
    ti_nxt   = ti_set || (ti_r && !(ctrl_wr && reg_wdata[CB_TI]));
    ri_nxt   = ri_set || (ri_r && !(ctrl_wr && reg_wdata[CB_RI]
                                    && (cnt_r == FIFO_EMPTY)));
    ovr_nxt  = ovr_set || (ovr_r && !(ctrl_wr && reg_wdata[CB_OVR]));
    perr_nxt = perr_set || (perr_r && !(ctrl_wr && reg_wdata[CB_PERR]));
    ctrl_view          = CTRL_RESET;
    ctrl_view[CB_OVR]  = ovr_r;
    ctrl_view[CB_PERR] = perr_r;
    ctrl_view[CB_THRE] = thre_r;
    ctrl_view[CB_REN]  = ren_r;
    ctrl_view[CB_TBX]  = tbx_r;
    ctrl_view[CB_RBX]  = mem_r[rp_r][8];
    ctrl_view[CB_TI]   = ti_r;
    ctrl_view[CB_RI]   = ri_r;
    flag_nxt           = '0;
    flag_nxt[CB_OVR]   = ovr_nxt;
    flag_nxt[CB_PERR]  = perr_nxt;
    flag_nxt[CB_TI]    = ti_nxt;
    flag_nxt[CB_RI]    = ri_nxt;
    irq_nxt  = |(flag_nxt & mask_nxt);
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DATA: rdata_nxt = mem_r[rp_r][7:0];
        ADDR_CTRL: rdata_nxt = ctrl_view;
        ADDR_FMT:  rdata_nxt = fmt_r;
        ADDR_BCON: rdata_nxt = bcon_r;
        ADDR_RLL:  rdata_nxt = rll_r;
        ADDR_RLH:  rdata_nxt = rlh_r;
        ADDR_MASK: rdata_nxt = mask_r;
        default:   rdata_nxt = UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_r   <= FMT_RESET;
      bcon_r  <= BCON_RESET;
      rll_r   <= RL_RESET;
      rlh_r   <= RL_RESET;
      mask_r  <= MASK_RESET;
      ren_r   <= 1'b0;
      tbx_r   <= 1'b0;
      ti_r    <= 1'b0;
      ri_r    <= 1'b0;
      ovr_r   <= 1'b0;
      perr_r  <= 1'b0;
      irq_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      fmt_r   <= fmt_nxt;
      bcon_r  <= bcon_nxt;
      rll_r   <= rll_nxt;
      rlh_r   <= rlh_nxt;
      mask_r  <= mask_nxt;
      ren_r   <= ren_nxt;
      tbx_r   <= tbx_nxt;
      ti_r    <= ti_nxt;
      ri_r    <= ri_nxt;
      ovr_r   <= ovr_nxt;
      perr_r  <= perr_nxt;
      irq_r   <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign tx_pin    = txd_r;
  assign irq       = irq_r;
endmodule

// [tb/ufb_uart_props.sv]
`timescale 1ns/10ps
module ufb_uart_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial lines and interrupt
  input wire logic       rx_pin,
  input wire logic       tx_pin,
  input wire logic       irq
);
  import ufb_pkg::*;
  logic [7:0]  mask_r, mask_nxt;
  logic [15:0] rl_r, rl_nxt;
  logic [2:0]  bc_r, bc_nxt;
  logic [31:0] low_r, low_nxt, div, bit_len;

  // Shadow of software settings, rebuilt from the writes
  always_comb begin
    mask_nxt = mask_r;
    rl_nxt   = rl_r;
    bc_nxt   = bc_r;
    if (reg_wr && reg_addr == ADDR_MASK) mask_nxt = reg_wdata;
    if (reg_wr && reg_addr == ADDR_RLL) rl_nxt[7:0] = reg_wdata;
    if (reg_wr && reg_addr == ADDR_RLH) rl_nxt[15:8] = reg_wdata;
    if (reg_wr && reg_addr == ADDR_BCON) begin
      bc_nxt = {reg_wdata[BB_EN], reg_wdata[BB_PS_HI:BB_PS_LO]};
    end
    low_nxt = tx_pin ? 32'h0 : low_r + 32'h1;
    case (bc_r[1:0])
      PS_DIV1: div = 32'h1;
      PS_DIV4: div = 32'h4;
      PS_DIV12: div = 32'hC;
      default: div = 32'h30;
    endcase
    bit_len = 32'h2 * (32'h10000 - {16'h0, rl_r}) * div;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= 8'h00;
      rl_r   <= 16'h0000;
      bc_r   <= 3'h0;
      low_r  <= 32'h0;
    end else begin
      mask_r <= mask_nxt;
      rl_r   <= rl_nxt;
      bc_r   <= bc_nxt;
      low_r  <= low_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_reset_idle: assert property ($rose(reset_n) |-> tx_pin && !irq)
    else $error("port not idle after reset");
  a_irq_masked_off: assert property (
    ((mask_r & 8'hC3) == 8'h00) && (($past(mask_r) & 8'hC3) == 8'h00) |-> !irq)
    else $error("interrupt with all sources masked");
  // Only software writes may lower the request
  a_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("interrupt dropped without a write");
  a_tx_off_idle: assert property (!bc_r[2] && !$past(bc_r[2]) |-> tx_pin)
    else $error("transmit active with generator off");
  a_bit_len_min: assert property (
    $rose(tx_pin) && bc_r[2] && $past(bc_r[2]) |-> low_r >= bit_len)
    else $error("low run shorter than one bit time");
  a_ti_at_stop: assert property (
    (mask_r == 8'h02) && $rose(irq) && !$past(reg_wr) && !$past(reg_wr, 2) |-> tx_pin)
    else $error("transmit done outside stop bit");
  a_ri_after_stop: assert property (
    (mask_r == 8'h01) && $rose(irq) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $past(rx_pin) && $past(rx_pin, 4))
    else $error("receive flag without high stop bit");

  c_tx_frame: cover property ($fell(tx_pin));
  c_irq_rise: cover property ($rose(irq));
  c_data_read: cover property (reg_rd && reg_addr == ADDR_DATA);
endmodule

bind ufb_uart ufb_uart_props u_props (
  .ref_clk  (ref_clk),
  .reset_n  (reset_n),
  .reg_addr (reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr   (reg_wr),
  .reg_rd   (reg_rd),
  .reg_rdata(reg_rdata),
  .rx_pin   (rx_pin),
  .tx_pin   (tx_pin),
  .irq      (irq)
);

// [tb/ufb_remote_node.sv]
`timescale 1ns/10ps
module ufb_remote_node (
  // Clock
  input wire logic ref_clk,
  // Serial lines seen from the remote end
  output logic     node_tx,
  input wire logic node_rx
);
  int bit_cyc = 16;
  initial node_tx = 1'b1;

  // Trailing idle bit keeps frames apart
  task automatic send_byte(input logic [7:0] b, input logic bad_stop);
    logic [10:0] f;
    f = {1'b1, ~bad_stop, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      node_tx <= f[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
  endtask

  task automatic recv_byte(output logic [7:0] b);
    int n;
    n = 0;
    // A low last data bit must not pass for the next start bit
    while (node_rx !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    while (node_rx !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      b[i] = node_rx;
    end
  endtask
endmodule

// [tb/test_ufb_uart.sv]
`timescale 1ns/10ps
module test_ufb_uart;
  import ufb_pkg::*;
  logic       ref_clk, reset_n, reg_wr, reg_rd, rx_pin, tx_pin, irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_v;
  int         failures, comparisons;

  ufb_uart u_dut (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),
    .reg_rd   (reg_rd),
    .reg_rdata(reg_rdata),
    .rx_pin   (rx_pin),
    .tx_pin   (tx_pin),
    .irq      (irq)
  );
  ufb_remote_node u_node (.ref_clk(ref_clk), .node_tx(rx_pin), .node_rx(tx_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Idle edge after each strobe, so no signal is assigned twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_reset_values();
    logic [7:0] exp [8];
    exp = '{8'h00, CTRL_RESET | 8'h20, FMT_RESET, BCON_RESET, RL_RESET, RL_RESET,
            MASK_RESET, UNMAPPED_RD};
    for (int i = 1; i < 8; i++) begin
      rd(i[2:0], rd_v);
      check("reset value", rd_v, exp[i]);
    end
    wr(ADDR_DATA, 8'h3C);
    rd(ADDR_CTRL, rd_v);
    check("holding full", rd_v[CB_THRE], 1'b0);
    repeat (40) @(posedge ref_clk);
    check("tx idle while off", tx_pin, 1'b1);
  endtask

  task automatic t_tx_frame();
    logic [7:0] b0, b1;
    wr(ADDR_RLL, 8'hF8);
    wr(ADDR_RLH, 8'hFF);
    wr(ADDR_MASK, 8'h02);
    fork
      begin
        u_node.recv_byte(b0);
        u_node.recv_byte(b1);
      end
      begin
        wr(ADDR_BCON, 8'h43);
        repeat (4) @(posedge ref_clk);
        wr(ADDR_DATA, 8'hA5);
        rd(ADDR_CTRL, rd_v);
        check("holding busy", rd_v[CB_THRE], 1'b0);
      end
    join
    check("first byte", b0, 8'h3C);
    check("second byte", b1, 8'hA5);
    repeat (40) @(posedge ref_clk);
    check("irq after frame", irq, 1'b1);
    rd(ADDR_CTRL, rd_v);
    check("tx done kept", rd_v[CB_TI], 1'b1);
    wr(ADDR_CTRL, 8'h02);
    repeat (3) @(posedge ref_clk);
    check("irq after clear", irq, 1'b0);
  endtask

  task automatic t_rx_fifo();
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_MASK, 8'h01);
    u_node.send_byte(8'h11, 1'b0);
    u_node.send_byte(8'hEE, 1'b1);
    u_node.send_byte(8'h22, 1'b0);
    u_node.send_byte(8'h33, 1'b0);
    u_node.send_byte(8'h44, 1'b0);
    check("irq on receive", irq, 1'b1);
    rd(ADDR_CTRL, rd_v);
    check("overrun", rd_v[CB_OVR], 1'b1);
    check("rx avail", rd_v[CB_RI], 1'b1);
    wr(ADDR_CTRL, 8'h11);
    rd(ADDR_CTRL, rd_v);
    check("avail kept", rd_v[CB_RI], 1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_DATA, rd_v);
      check("fifo head", rd_v, 8'h11 * (i + 1));
    end
    wr(ADDR_CTRL, 8'h91);
    rd(ADDR_CTRL, rd_v);
    check("flags cleared", rd_v & 8'h81, 8'h00);
    // Node's tenth bit is high and lands in the parity slot
    wr(ADDR_FMT, 8'h13);
    u_node.send_byte(8'h03, 1'b0);
    rd(ADDR_CTRL, rd_v);
    check("parity ok", rd_v[CB_PERR], 1'b0);
    u_node.send_byte(8'h01, 1'b0);
    rd(ADDR_CTRL, rd_v);
    check("parity error", rd_v[CB_PERR], 1'b1);
    rd(ADDR_DATA, rd_v);
    check("parity byte", rd_v, 8'h03);
    wr(ADDR_FMT, FMT_RESET);
  endtask

  task automatic t_prescale();
    logic [1:0] code [4] = '{PS_DIV1, PS_DIV4, PS_DIV12, PS_DIV48};
    int         div [4] = '{1, 4, 12, 48};
    int         n, bit_c;
    for (int i = 0; i < 4; i++) begin
      bit_c = 2 * (65536 - 'hFFF8) * div[i];
      wr(ADDR_BCON, {6'h10, code[i]});
      wr(ADDR_DATA, 8'h01);
      n = 0;
      while (tx_pin !== 1'b0 && n < 2000) begin
        @(posedge ref_clk);
        n++;
      end
      n = 0;
      while (tx_pin === 1'b0 && n < 5000) begin
        @(posedge ref_clk);
        n++;
      end
      check("start bit length", n >= bit_c && n <= bit_c + 1, 1'b1);
      repeat (9 * bit_c + 4) @(posedge ref_clk);
    end
    // Turning the generator off mid-frame must release the line
    wr(ADDR_DATA, 8'h00);
    repeat (40) @(posedge ref_clk);
    check("frame running", tx_pin, 1'b0);
    wr(ADDR_BCON, BCON_RESET);
    repeat (2) @(posedge ref_clk);
    check("abort on disable", tx_pin, 1'b1);
  endtask

  initial begin
    failures    = 0;
    comparisons = 0;
    reset_n     = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 3'h0;
    reg_wdata   = 8'h00;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset_values();
    t_tx_frame();
    t_rx_fifo();
    t_prescale();
    wrap_up();
  end

  // Whole run needs about 12k cycles
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule
